// ==== common/rlbt_pkg.sv ====
// Constants and types shared by the return-link burst timing block
package rlbt_pkg;
	localparam int REF_W = 42;
	localparam int SYMCNT_W = 16;
	localparam int BYTECNT_W = 16;
	localparam int FRAME_DELAY = 2;
	localparam int FRAME_W = 8;
	localparam logic [7:0] CELL_BYTES = 8'd53;
	localparam logic [7:0] PACKET_BYTES = 8'd188;
	localparam logic [REF_W-1:0] REF_RESET = '0;
	localparam logic [SYMCNT_W-1:0] RX_DELAY_RESET = '0;
	localparam int CLK_MHZ = 25;
	localparam int LINK_MHZ = 27;
	typedef enum logic [1:0] {BK_TRAFFIC, BK_ACQ, BK_KEEPALIVE, BK_LOGON} rlbt_kind_e;
	typedef enum {ST_IDLE, ST_WAIT, ST_PRE_GUARD, ST_PREAMBLE, ST_BODY, ST_TRAIL, ST_GUARD} rlbt_state_e;
endpackage

// ==== rtl/rlbt_burst_timing.sv ====
// Return-link reference counter, superframe timing and burst serialiser
`timescale 1ns/10ps
`default_nettype none
module rlbt_burst_timing (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ref_clk_in,
	input wire logic adaptive_mode,
	input wire logic ref_valid,
	input wire logic [rlbt_pkg::REF_W-1:0] ref_value,
	input wire logic ref_on_signalling_pid,
	input wire logic frame_start,
	input wire logic [rlbt_pkg::SYMCNT_W-1:0] rx_delay,
	input wire logic plan_valid,
	input wire logic [rlbt_pkg::REF_W-1:0] plan_superframe_start,
	input wire logic [rlbt_pkg::REF_W-1:0] plan_burst_offset,
	input wire logic [1:0] plan_kind,
	input wire logic [rlbt_pkg::BYTECNT_W-1:0] plan_slot_bytes,
	input wire logic [rlbt_pkg::BYTECNT_W-1:0] plan_preamble_bits,
	input wire logic [rlbt_pkg::BYTECNT_W-1:0] plan_guard_counts,
	input wire logic [rlbt_pkg::BYTECNT_W-1:0] plan_prefix_bytes,
	input wire logic [rlbt_pkg::BYTECNT_W-1:0] plan_trail_bits,
	input wire logic packet_mode,
	input wire logic packet_capable,
	input wire logic payload_bit,
	output logic payload_ready,
	output logic [rlbt_pkg::REF_W-1:0] local_ref,
	output logic superframe_start,
	output logic burst_active,
	output logic tx_bit,
	output logic tx_bit_valid,
	output logic preamble_active,
	output logic guard_active,
	output logic [rlbt_pkg::BYTECNT_W-1:0] packets_in_slot,
	output logic logon_packet_flag
);
	import rlbt_pkg::*;
	logic [2:0] clk_sync_q;
	logic ref_tick;
	logic [REF_W-1:0] local_ref_q;
	logic [REF_W-1:0] sof_ref_q [0:FRAME_DELAY];
	logic [REF_W-1:0] sched_q;
	logic [REF_W-1:0] plan_sf_q;
	logic superframe_start_q;
	logic sf_armed_q;
	rlbt_kind_e kind_q;
	rlbt_state_e state_q;
	logic [BYTECNT_W-1:0] pre_len_q, body_len_q, trail_len_q, guard_len_q;
	logic [BYTECNT_W-1:0] cnt_q;
	logic [BYTECNT_W-1:0] body_bytes;
	logic tx_bit_q, tx_valid_q, payload_ready_q;
	logic [BYTECNT_W-1:0] packets_q;

	// Two flops before the link clock is looked at, third for edge detect
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_sync_q <= '0;
		end else begin
			clk_sync_q <= {clk_sync_q[1:0], ref_clk_in};
		end
	end
	assign ref_tick = clk_sync_q[1] & ~clk_sync_q[2];


	// Frame start snapshots; a reference is tied to the frame two back
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i <= FRAME_DELAY; i++) begin
				sof_ref_q[i] <= REF_RESET;
			end
		end else if (frame_start) begin
			sof_ref_q[0] <= local_ref_q;
			for (int i = 1; i <= FRAME_DELAY; i++) begin
				sof_ref_q[i] <= sof_ref_q[i-1];
			end
		end
	end


	// Counter free-runs on recovered edges and snaps to each reference carried on the signalling PID, or in adaptive mode to it plus the count since the paired frame
	// Pairing takes the snapshot two frame starts before ref_valid, so a value
	// whose second fragment lands frames later is paired with a later frame
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			local_ref_q <= REF_RESET;
		end else if (ref_valid && ref_on_signalling_pid) begin
			if (adaptive_mode) begin
				// Value belongs to the SOF two frames before its top bit arrived
				local_ref_q <= ref_value + (local_ref_q - sof_ref_q[FRAME_DELAY]);
			end else begin
				local_ref_q <= ref_value;
			end
		end else if (ref_tick) begin
			local_ref_q <= local_ref_q + 1'b1;
		end
	end


	// Plan latch: superframe start as given by the plan
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			plan_sf_q <= REF_RESET;
		end else if (plan_valid) begin
			plan_sf_q <= plan_superframe_start;
		end
	end

	// Receiver delay moves the burst only; the superframe mark stays on the plan value
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sched_q <= REF_RESET;
		end else if (plan_valid) begin
			sched_q <= plan_superframe_start + plan_burst_offset - REF_W'(rx_delay);
		end
	end

	// Armed until the first match, so a plan gives one superframe mark
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sf_armed_q <= 1'b0;
		end else if (plan_valid) begin
			sf_armed_q <= 1'b1;
		end else if (sf_armed_q && local_ref_q == plan_sf_q) begin
			sf_armed_q <= 1'b0;
		end
	end

	// A new plan in the match cycle wins and rearms
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			superframe_start_q <= 1'b0;
		end else begin
			superframe_start_q <= sf_armed_q && !plan_valid && local_ref_q == plan_sf_q;
		end
	end


	// Slot size to packet count; only the prefix bytes come off first
	always_comb begin
		body_bytes = plan_slot_bytes - plan_prefix_bytes;
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			packets_q <= '0;
		end else if (plan_valid) begin
			packets_q <= body_bytes / BYTECNT_W'(PACKET_BYTES);
		end
	end


	// Burst sequencer: one field after another, one bit per clock
	// A plan that arrives while a burst runs moves the schedule, superframe and packet count latches, not the burst
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			kind_q <= BK_TRAFFIC;
			cnt_q <= '0;
			pre_len_q <= '0;
			body_len_q <= '0;
			trail_len_q <= '0;
			guard_len_q <= '0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (plan_valid) begin
						kind_q <= rlbt_kind_e'(plan_kind);
						pre_len_q <= plan_preamble_bits;
						guard_len_q <= plan_guard_counts;
						if (rlbt_kind_e'(plan_kind) == BK_TRAFFIC) begin
							if (packet_mode) begin
								// Whole packets only; leftover slot bytes stay idle
								body_len_q <= BYTECNT_W'((body_bytes / BYTECNT_W'(PACKET_BYTES))
									* BYTECNT_W'(PACKET_BYTES) * 8);
							end else begin
								body_len_q <= BYTECNT_W'((plan_prefix_bytes + (body_bytes / BYTECNT_W'(CELL_BYTES))
									* BYTECNT_W'(CELL_BYTES)) * 8);
							end
						end else begin
							body_len_q <= BYTECNT_W'(plan_prefix_bytes * 8);
						end
						trail_len_q <= plan_trail_bits;
						state_q <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (local_ref_q == sched_q) begin
						cnt_q <= '0;
						state_q <= (kind_q == BK_ACQ) ? ST_PRE_GUARD : ST_PREAMBLE;
					end
				end
				ST_PRE_GUARD: begin
					if (cnt_q >= guard_len_q) begin
						cnt_q <= '0;
						state_q <= ST_PREAMBLE;
					end else if (ref_tick) begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				ST_PREAMBLE: begin
					if (cnt_q + 1'b1 >= pre_len_q) begin
						cnt_q <= '0;
						state_q <= ST_BODY;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				ST_BODY: begin
					if (cnt_q + 1'b1 >= body_len_q) begin
						cnt_q <= '0;
						state_q <= (trail_len_q != '0) ? ST_TRAIL : ST_GUARD;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				ST_TRAIL: begin
					if (cnt_q + 1'b1 >= trail_len_q) begin
						cnt_q <= '0;
						state_q <= ST_GUARD;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				ST_GUARD: begin
					if (cnt_q >= guard_len_q) begin
						cnt_q <= '0;
						state_q <= ST_IDLE;
					end else if (ref_tick) begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
			endcase
		end
	end


	// Bits are valid through preamble, body and trailer; the guard sends nothing
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_valid_q <= 1'b0;
		end else begin
			tx_valid_q <= state_q == ST_PREAMBLE || state_q == ST_BODY || state_q == ST_TRAIL;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			payload_ready_q <= 1'b0;
		end else begin
			payload_ready_q <= state_q == ST_BODY || state_q == ST_TRAIL;
		end
	end

	// Serial output; the source shifts fields out most significant bit first
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_bit_q <= 1'b0;
		end else if (kind_q == BK_LOGON && state_q == ST_BODY && cnt_q == '0) begin
			tx_bit_q <= packet_capable;
		end else begin
			tx_bit_q <= payload_bit;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			logon_packet_flag <= 1'b0;
		end else begin
			logon_packet_flag <= packet_capable;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			burst_active <= 1'b0;
		end else begin
			burst_active <= state_q != ST_IDLE && state_q != ST_WAIT;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			preamble_active <= 1'b0;
		end else begin
			preamble_active <= state_q == ST_PREAMBLE;
		end
	end

	// Guard before an acquisition burst shows the same as the trailing guard
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			guard_active <= 1'b0;
		end else begin
			guard_active <= state_q == ST_GUARD || state_q == ST_PRE_GUARD;
		end
	end


	assign local_ref = local_ref_q;
	assign superframe_start = superframe_start_q;
	assign tx_bit = tx_bit_q;
	assign tx_bit_valid = tx_valid_q;
	assign payload_ready = payload_ready_q;
	assign packets_in_slot = packets_q;
endmodule
`default_nettype wire

// ==== test/rlbt_burst_timing_chk.sv ====
// Port assertions for the burst timing block
`timescale 1ns/10ps
`default_nettype none
module rlbt_burst_timing_chk (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ref_clk_in,
	input wire logic adaptive_mode,
	input wire logic ref_valid,
	input wire logic [rlbt_pkg::REF_W-1:0] ref_value,
	input wire logic ref_on_signalling_pid,
	input wire logic [rlbt_pkg::REF_W-1:0] plan_superframe_start,
	input wire logic [rlbt_pkg::REF_W-1:0] local_ref,
	input wire logic superframe_start,
	input wire logic preamble_active,
	input wire logic guard_active,
	input wire logic payload_ready,
	input wire logic tx_bit_valid
);
	import rlbt_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	wire logic ld = ref_valid && ref_on_signalling_pid;
	a_sf_pulse_once: assert property (superframe_start |=> !superframe_start) else $error("pulse too long");
	a_sf_on_match: assert property (superframe_start |-> $past(local_ref) == plan_superframe_start)
		else $error("superframe pulse off match");
	a_ref_load: assert property (ld && !adaptive_mode |=> local_ref == $past(ref_value))
		else $error("reference not loaded");
	a_count_step: assert property (!ld |=> local_ref - $past(local_ref) <= 1) else $error("counter jumped");
	// Six quiet cycles cover the synchroniser depth plus the edge detector
	a_ref_still: assert property ((!ref_clk_in && !ref_valid) [*6] |-> $stable(local_ref))
		else $error("counter moved without reference edge");
	a_flag_split: assert property (!(preamble_active && guard_active)) else $error("preamble in guard");
	a_body_order: assert property (payload_ready |-> !preamble_active && !guard_active)
		else $error("payload taken out of order");
	a_bits_follow: assert property ($rose(preamble_active) |=> tx_bit_valid) else $error("bits not valid");
	c_sf: cover property (superframe_start);
	c_pre: cover property ($rose(preamble_active));
	c_guard: cover property ($rose(guard_active));
endmodule
bind rlbt_burst_timing rlbt_burst_timing_chk i_chk (.*);
`default_nettype wire

// ==== test/rlbt_fwd_link_model.sv ====
// Forward-link side: recovered reference clock and frame start events
`timescale 1ns/10ps
`default_nettype none
module rlbt_fwd_link_model (
	input wire logic core_clk,
	input wire logic run,
	output logic ref_clk_in,
	output logic frame_start,
	output int edges
);
	int fcnt = 0;
	// Stops only when low, so a frozen counter is never left mid-cycle
	initial begin
		ref_clk_in = 1'b0;
		frame_start = 1'b0;
		edges = 0;
		#7;
		forever begin
			#160;
			if (run || ref_clk_in) begin
				ref_clk_in = !ref_clk_in;
				if (ref_clk_in) edges++;
			end
		end
	end
	always @(negedge core_clk) begin
		fcnt <= (fcnt + 1) % 32;
		frame_start <= (fcnt == 0);
	end
endmodule
`default_nettype wire

// ==== test/rlbt_burst_timing_bench.sv ====
// Self-checking bench for the burst timing block
`timescale 1ns/10ps
`default_nettype none
module rlbt_burst_timing_bench;
	import rlbt_pkg::*;
	logic core_clk, rst_n, adaptive_mode, ref_valid, ref_on_signalling_pid, plan_valid, run;
	logic packet_mode, packet_capable, payload_bit, ref_clk_in, frame_start;
	logic [REF_W-1:0] ref_value, plan_superframe_start, plan_burst_offset, local_ref, exp_ref;
	logic [1:0] plan_kind;
	logic [SYMCNT_W-1:0] rx_delay;
	logic [BYTECNT_W-1:0] plan_slot_bytes, plan_preamble_bits, plan_guard_counts, plan_prefix_bytes;
	logic [BYTECNT_W-1:0] plan_trail_bits, packets_in_slot;
	logic payload_ready, superframe_start, burst_active, tx_bit, tx_bit_valid;
	logic preamble_active, guard_active, logon_packet_flag;
	logic [15:0] lf = 16'hf796;
	int err_count = 0, n_checks = 0, edges, e0, npre, cyc = 0;
	int nbits, npay, ebody;
	logic pa_prev;
	rlbt_burst_timing i_dut (.*);
	rlbt_fwd_link_model i_fwd (.core_clk, .run, .ref_clk_in, .frame_start, .edges);
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	task automatic check(input string what, input logic [REF_W-1:0] exp, input logic [REF_W-1:0] got);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic load(input logic pid, input logic adapt);
		@(negedge core_clk);
		ref_value = {lf, ~lf, lf[9:0]};
		ref_on_signalling_pid = pid;
		adaptive_mode = adapt;
		ref_valid = 1'b1;
		@(negedge core_clk);
		ref_valid = 1'b0;
		if (pid) exp_ref = ref_value;
		repeat (8) @(negedge core_clk);
	endtask
	task automatic spin(input int n);
		e0 = edges;
		run = 1'b1;
		repeat (n) @(negedge core_clk);
		run = 1'b0;
		repeat (20) @(negedge core_clk);
		exp_ref = exp_ref + REF_W'(edges - e0);
	endtask
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	always @(negedge core_clk) begin
		lf <= lfsr(lf);
		payload_bit <= lf[0];
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 40000) begin
			err_count++;
			summarize();
		end
	end
	initial begin
		{rst_n, adaptive_mode, ref_valid, ref_on_signalling_pid, plan_valid, run} = '0;
		{packet_mode, packet_capable, ref_value, plan_superframe_start, plan_burst_offset, plan_kind} = '0;
		{rx_delay, plan_slot_bytes, plan_preamble_bits, plan_guard_counts, plan_prefix_bytes, plan_trail_bits} = '0;
		exp_ref = REF_RESET;
		repeat (12) @(negedge core_clk);
		rst_n = 1'b1;
		repeat (2) @(negedge core_clk);
		for (int i = 0; i < 4; i++) begin
			load(i[0], 1'b0);
			check("local_ref", exp_ref, local_ref);
		end
		spin(200);
		check("count", exp_ref, local_ref);
		// Frozen counter makes every frame snapshot equal, so pairing yields the value itself
		repeat (100) @(negedge core_clk);
		load(1'b1, 1'b1);
		check("paired", exp_ref, local_ref);
		for (int k = 0; k < 5; k++) begin
			@(negedge core_clk);
			{plan_kind, packet_mode, packet_capable} = {k[1:0], k == 4, lf[1]};
			{plan_burst_offset, rx_delay, plan_prefix_bytes} = {REF_W'(4 + k), 16'(k), 16'(k)};
			{plan_slot_bytes, plan_preamble_bits, plan_trail_bits, plan_guard_counts} = {16'(200), 16'(8 + k), 16'(2), 16'(2)};
			plan_superframe_start = exp_ref + 42'h3;
			plan_valid = 1'b1;
			@(negedge core_clk);
			plan_valid = 1'b0;
			check("packets", (200 - k) / 188, packets_in_slot);
			check("logon_flag", REF_W'(packet_capable), logon_packet_flag);
			e0 = edges;
			run = 1'b1;
			for (int n = 0; n < 300 && superframe_start !== 1'b1; n++) @(negedge core_clk);
			check("sf_ref", plan_superframe_start, local_ref);
			for (int n = 0; n < 300 && burst_active !== 1'b1; n++) @(negedge core_clk);
			check("burst", 1, burst_active);
			npre = int'(preamble_active === 1'b1);
			nbits = int'(tx_bit_valid === 1'b1);
			npay = int'(payload_ready === 1'b1);
			pa_prev = preamble_active;
			for (int n = 0; n < 6000 && (burst_active !== 1'b0 || guard_active !== 1'b0); n++) begin
				@(negedge core_clk);
				npre += int'(preamble_active === 1'b1);
				nbits += int'(tx_bit_valid === 1'b1);
				npay += int'(payload_ready === 1'b1);
				if (k == 3 && pa_prev === 1'b1 && preamble_active === 1'b0) check("logon_bit", REF_W'(packet_capable), REF_W'(tx_bit));
				pa_prev = preamble_active;
			end
			check("preamble", 8 + k, npre);
			ebody = (k == 0) ? (200 / 53) * 53 * 8 : (k == 4) ? ((200 - k) / 188) * 188 * 8 : k * 8;
			check("tx_bits", 8 + k + ebody + 2, nbits);
			check("payload", ebody + 2, npay);
			run = 1'b0;
			repeat (20) @(negedge core_clk);
			exp_ref = exp_ref + REF_W'(edges - e0);
			check("count", exp_ref, local_ref);
		end
		summarize();
	end
endmodule
`default_nettype wire
